// file: hw/rce_encoder.sv
// Remote-control word encoder with APB control and status
//
// Local design decisions: the APB interface to the registers and the register addresses.
`default_nettype none
// What this block does
// - Trigger rise captures the eight data lines
// - Each cycle sends the word three times
// - Trigger still high starts another cycle
// - Inputs resampled each cycle, lag under 150ms
// - Sending continues while trigger stays high
// - Data select high: high one, low zero
// - Data select low: high one, low open
// - Address select pattern picks one/zero/open coding
// - Floating data select reads low
// - Floating address selects read low and high
// - Floating address reads high, data low
// - Both ends use matching coding selects
// - Send address bits 0-9 then data 0-7
// - Trigger fall finishes the current cycle
module rce_encoder
    import rce_pkg::*;
#(
    parameter int CHIP_CYCLES = rce_pkg::CHIP_CYCLES_DEF,
    parameter int LAG_CYCLES = rce_pkg::MAX_LAG_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic sendTrigger,
    input wire logic [rce_pkg::ADDR_W-1:0] addressWordLines,
    input wire logic [rce_pkg::ADDR_W-1:0] addressWordLinesDriven,
    input wire logic [rce_pkg::DATA_W-1:0] payloadLines,
    input wire logic [rce_pkg::DATA_W-1:0] payloadLinesDriven,
    input wire logic dataBitTypeSelect,
    input wire logic dataBitTypeSelectDriven,
    input wire logic addrBitTypeSelectLo,
    input wire logic addrBitTypeSelectLoDriven,
    input wire logic addrBitTypeSelectHi,
    input wire logic addrBitTypeSelectHiDriven,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txData,
    output logic txActive
);
    import rce_pkg::*;

    localparam int CW = $clog2(CHIP_CYCLES + 1);
    localparam int LW = $clog2(LAG_CYCLES + 2);

    logic [PIN_W-1:0] pinVal;
    logic trigPin;
    logic dCfg;
    logic aLo;
    logic aHi;
    logic [ADDR_W-1:0] addrVal;
    logic [DATA_W-1:0] dataVal;
    logic [2*WORD_BITS-1:0] liveSym;

    logic [1:0] ctrl_r;
    rce_state_e state_r;
    logic [CW-1:0] chipCnt_r;
    logic [1:0] chipIdx_r;
    logic [4:0] bitIdx_r;
    logic [1:0] wordIdx_r;
    logic [2*WORD_BITS-1:0] captSym_r;
    logic [ADDR_W-1:0] captAddr_r;
    logic [DATA_W-1:0] captData_r;
    logic [2:0] captCfg_r;
    logic [15:0] cycleCnt_r;
    logic [LW-1:0] lagCnt_r;

    logic trigActive;
    logic chipTick;
    logic chipLast;
    logic bitLast;
    logic gapLast;
    logic endOfWord;
    logic endOfCycle;
    logic captureNow;
    logic curChip;
    logic [3:0] curPat;
    logic accessNow;
    logic writeNow;
    logic regHit;
    logic [31:0] readMux;

    // Pins pass three flops; undriven pins take their pulls
    rce_pin_sync #(
        .W(PIN_W),
        .PULL(PIN_PULL)
    ) u_pins (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pinLevel({payloadLines, addressWordLines, addrBitTypeSelectHi,
                   addrBitTypeSelectLo, dataBitTypeSelect, sendTrigger}),
        .pinDriven({payloadLinesDriven, addressWordLinesDriven, addrBitTypeSelectHiDriven,
                    addrBitTypeSelectLoDriven, dataBitTypeSelectDriven, 1'b1}),
        .pinValue(pinVal)
    );

    assign trigPin = pinVal[PIN_TRIG];
    assign dCfg = pinVal[PIN_DCFG];
    assign aLo = pinVal[PIN_ALO];
    assign aHi = pinVal[PIN_AHI];
    assign addrVal = pinVal[PIN_ADDR +: ADDR_W];
    assign dataVal = pinVal[PIN_DATA +: DATA_W];

    // Level to symbol coding, address first then data
    genvar gi;
    for (gi = 0; gi < WORD_BITS; gi++) begin : g_code
        if (gi < ADDR_W) begin : g_addr
            // 01 sends low as open, 10 sends high as open
            assign liveSym[2*gi +: 2] = rce_code(addrVal[gi], aHi & ~aLo, aLo & ~aHi);
        end else begin : g_data
            assign liveSym[2*gi +: 2] = rce_code(dataVal[gi-ADDR_W], 1'b0, ~dCfg);
        end
    end

    // Sequencing terms
    assign trigActive = (trigPin & ctrl_r[CTRL_PIN_EN]) | ctrl_r[CTRL_SW_TRIG];
    assign chipTick = chipCnt_r == CW'(CHIP_CYCLES - 1);
    assign chipLast = chipTick && chipIdx_r == 2'(CHIPS_PER_BIT - 1);
    assign bitLast = state_r == ST_BITS && chipLast && bitIdx_r == 5'(WORD_BITS - 1);
    assign gapLast = chipTick && bitIdx_r == 5'(GAP_CHIPS - 1);
    assign endOfWord = state_r == ST_GAP && gapLast;
    assign endOfCycle = endOfWord && wordIdx_r == 2'(WORDS_PER_CYCLE - 1);
    assign captureNow = trigActive && (state_r == ST_IDLE || endOfCycle);

    // Cycle state machine
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (trigActive) begin
                        state_r <= ST_BITS;
                    end
                end
                ST_BITS: begin
                    if (bitLast) begin
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (endOfWord) begin
                        // Stop only at a cycle boundary
                        state_r <= (endOfCycle && !trigActive) ? ST_IDLE : ST_BITS;
                    end
                end
            endcase
        end
    end

    // Chip, bit and word counters
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chipCnt_r <= '0;
            chipIdx_r <= 2'h0;
            bitIdx_r <= 5'h00;
        end else if (state_r == ST_IDLE || captureNow) begin
            chipCnt_r <= '0;
            chipIdx_r <= 2'h0;
            bitIdx_r <= 5'h00;
        end else begin
            chipCnt_r <= chipTick ? '0 : chipCnt_r + CW'(1);
            if (chipTick && state_r == ST_BITS) begin
                chipIdx_r <= chipIdx_r + 2'h1;
                if (chipLast) begin
                    bitIdx_r <= bitLast ? 5'h00 : bitIdx_r + 5'h01;
                end
            end else if (chipTick) begin
                bitIdx_r <= gapLast ? 5'h00 : bitIdx_r + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wordIdx_r <= 2'h0;
        end else if (state_r == ST_IDLE || captureNow) begin
            wordIdx_r <= 2'h0;
        end else if (endOfWord) begin
            wordIdx_r <= wordIdx_r + 2'h1;
        end
    end

    // Sample address, data and coding-select pins once per cycle and hold them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            captSym_r <= '0;
            captAddr_r <= '0;
            captData_r <= '0;
            captCfg_r <= 3'h0;
        end else if (captureNow) begin
            captSym_r <= liveSym;
            captAddr_r <= addrVal;
            captData_r <= dataVal;
            captCfg_r <= {aHi, aLo, dCfg};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cycleCnt_r <= 16'h0000;
        end else if (endOfCycle) begin
            cycleCnt_r <= cycleCnt_r + 16'h0001;
        end
    end

    // Current chip of the current bit
    always_comb begin
        unique case (rce_sym_e'(captSym_r[2*bitIdx_r +: 2]))
            SYM_ONE: curPat = PAT_ONE;
            SYM_OPEN: curPat = PAT_OPEN;
            SYM_ZERO: curPat = PAT_ZERO;
            default: curPat = PAT_ZERO;
        endcase
        curChip = curPat[2'(CHIPS_PER_BIT - 1) - chipIdx_r];
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            txData <= 1'b0;
            txActive <= 1'b0;
        end else begin
            txData <= state_r == ST_BITS && curChip;
            txActive <= state_r != ST_IDLE;
        end
    end

    // APB slave, one wait state
    assign accessNow = psel && penable && !pready;
    assign writeNow = psel && penable && pready && pwrite && !pslverr;
    assign regHit = paddr == CTRL_OFS || paddr == STAT_OFS || paddr == CAPT_OFS ||
                    paddr == PINS_OFS;

    always_comb begin
        unique case (paddr)
            CTRL_OFS: readMux = {30'h0, ctrl_r};
            STAT_OFS: readMux = {cycleCnt_r, 9'h000, trigPin, wordIdx_r, 2'h0, state_r};
            CAPT_OFS: readMux = {11'h000, captCfg_r, captData_r, captAddr_r};
            PINS_OFS: readMux = {10'h000, pinVal};
            default: readMux = 32'h00000000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= accessNow;
            pslverr <= accessNow && !regHit;
            if (accessNow) begin
                prdata <= regHit ? readMux : 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
        end else if (writeNow && paddr == CTRL_OFS && pstrb[0]) begin
            ctrl_r <= pwdata[1:0];
        end
    end

    // Cycle length since the last capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lagCnt_r <= '0;
        end else if (captureNow || state_r == ST_IDLE) begin
            lagCnt_r <= '0;
        end else if (lagCnt_r != '1) begin
            lagCnt_r <= lagCnt_r + LW'(1);
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_capture_data: assert property (captureNow |=> captData_r == $past(dataVal))
        else $error("data lines not captured at cycle start");

    a_three_words: assert property (endOfWord && wordIdx_r != 2'(WORDS_PER_CYCLE - 1)
        |=> state_r == ST_BITS && wordIdx_r == $past(wordIdx_r) + 2'h1)
        else $error("cycle ended before three words");

    a_restart_held: assert property (endOfCycle && trigActive
        |=> state_r == ST_BITS && bitIdx_r == 5'h00 && wordIdx_r == 2'h0)
        else $error("held trigger did not restart cycle");

    a_lag_bound: assert property (lagCnt_r < LW'(LAG_CYCLES))
        else $error("cycle longer than resample lag bound");

    a_stop_on_low: assert property (endOfCycle && !trigActive |=> state_r == ST_IDLE)
        else $error("sending did not stop after trigger low");

    a_finish_cycle: assert property (state_r != ST_IDLE && !endOfCycle
        |=> state_r != ST_IDLE)
        else $error("cycle aborted mid-word");

    a_data_coding: assert property (captureNow |=> rce_sym_e'(captSym_r[2*ADDR_W +: 2]) ==
        ($past(dataVal[0]) ? SYM_ONE : ($past(dCfg) ? SYM_ZERO : SYM_OPEN)))
        else $error("data bit coded wrongly");

    a_addr_coding: assert property (captureNow ##1 $past(aHi) && !$past(aLo)
        |-> rce_sym_e'(captSym_r[1:0]) == ($past(addrVal[0]) ? SYM_OPEN : SYM_ZERO))
        else $error("address bit coded wrongly for pattern 10");

    a_hold_stable: assert property (state_r != ST_IDLE && !captureNow
        |=> $stable(captSym_r) && $stable(captCfg_r))
        else $error("captured word changed inside cycle");

    a_first_bit: assert property (state_r == ST_IDLE && captureNow
        |=> (bitIdx_r == 5'h00) [*2])
        else $error("word did not start at address bit 0");

    a_apb_ready: assert property (accessNow |=> pready ##1 !pready)
        else $error("apb ready not one cycle");

    a_gap_low: assert property (state_r != ST_BITS |=> !txData)
        else $error("chip sent outside the bit phase");

    a_active_flag: assert property (txActive == ($past(state_r) != ST_IDLE))
        else $error("active flag does not follow the cycle");

    a_pslverr_map: assert property (accessNow && !regHit |=> pready && pslverr)
        else $error("unmapped offset not refused");

    c_restart: cover property (endOfCycle && trigActive);
    c_stop: cover property (endOfCycle && !trigActive);
    c_open_bit: cover property (captureNow && liveSym[2*ADDR_W +: 2] == SYM_OPEN);
    c_bad_addr: cover property (pready && pslverr);
    c_sw_trigger: cover property (captureNow && ctrl_r[CTRL_SW_TRIG]);
endmodule : rce_encoder
`default_nettype wire

// file: hw/rce_pkg.sv
// Constants, layouts and types shared by the remote-control encoder
`default_nettype none
package rce_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int WORD_BITS = ADDR_W + DATA_W;
    localparam int WORDS_PER_CYCLE = 3;
    localparam int CHIPS_PER_BIT = 4;
    localparam int GAP_CHIPS = 8;
    // Clock and timing
    localparam int CLK_HZ = 25_000_000;
    localparam int CHIP_TIME_US = 400;
    localparam int CHIP_CYCLES_DEF = CHIP_TIME_US * (CLK_HZ / 1_000_000);
    localparam int MAX_LAG_MS = 150;
    localparam int MAX_LAG_CYCLES = MAX_LAG_MS * (CLK_HZ / 1000);
    // Pin vector layout
    localparam int PIN_TRIG = 0;
    localparam int PIN_DCFG = 1;
    localparam int PIN_ALO = 2;
    localparam int PIN_AHI = 3;
    localparam int PIN_ADDR = 4;
    localparam int PIN_DATA = PIN_ADDR + ADDR_W;
    localparam int PIN_W = PIN_DATA + DATA_W;
    // Levels of floating pins: data, address, cfg hi, cfg lo, data cfg, trigger
    localparam logic [PIN_W-1:0] PIN_PULL = {8'h00, 10'h3FF, 1'b1, 1'b0, 1'b0, 1'b0};
    // APB register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] CAPT_OFS = 8'h08;
    localparam logic [7:0] PINS_OFS = 8'h0C;
    localparam int CTRL_PIN_EN = 0;
    localparam int CTRL_SW_TRIG = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    // Chip patterns, sent most significant chip first
    localparam logic [3:0] PAT_ZERO = 4'h8;
    localparam logic [3:0] PAT_ONE = 4'hE;
    localparam logic [3:0] PAT_OPEN = 4'hC;

    typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_OPEN} rce_sym_e;
    typedef enum logic [1:0] {ST_IDLE, ST_BITS, ST_GAP} rce_state_e;

    // Line level to symbol, given which level is sent as open
    function automatic rce_sym_e rce_code(input logic level, input logic highOpen,
                                          input logic lowOpen);
        if (level) begin
            return highOpen ? SYM_OPEN : SYM_ONE;
        end
        return lowOpen ? SYM_OPEN : SYM_ZERO;
    endfunction : rce_code
endpackage : rce_pkg
`default_nettype wire

// file: hw/rce_pin_sync.sv
// Three-flop pin synchroniser with pull level for undriven pins
`default_nettype none
module rce_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] PULL = '0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] pinLevel,
    input wire logic [W-1:0] pinDriven,
    output logic [W-1:0] pinValue
);
    genvar gi;
    for (gi = 0; gi < W; gi++) begin : g_pin
        logic levMeta_r;
        logic levSync_r;
        logic drvMeta_r;
        logic drvSync_r;
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                levMeta_r <= 1'b0;
                levSync_r <= 1'b0;
                drvMeta_r <= 1'b0;
                drvSync_r <= 1'b0;
            end else begin
                levMeta_r <= pinLevel[gi];
                levSync_r <= levMeta_r;
                drvMeta_r <= pinDriven[gi];
                drvSync_r <= drvMeta_r;
            end
        end
        // Floating pin reads its pull level
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                pinValue[gi] <= PULL[gi];
            end else begin
                pinValue[gi] <= drvSync_r ? levSync_r : PULL[gi];
            end
        end
    end
endmodule : rce_pin_sync
`default_nettype wire

// file: verification/rce_rx_model.sv
// Far-end receiver model: chip decoder, address compare, data outputs
`default_nettype none
module rce_rx_model #(
    parameter int CHIP = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic txData,
    input wire logic txActive,
    input wire logic [2*rce_pkg::ADDR_W-1:0] localSyms,
    output logic wordValid,
    output logic [2*rce_pkg::WORD_BITS-1:0] wordSyms,
    output logic addrMatch,
    output logic [rce_pkg::DATA_W-1:0] dataOut
);
    timeunit 1ns;
    timeprecision 1ps;
    import rce_pkg::*;
    int cnt;
    int chipIdx;
    logic [3:0] chips;
    logic [2*WORD_BITS-1:0] acc;

    always_comb chipIdx = (cnt / CHIP) % (4 * WORD_BITS + GAP_CHIPS);

    function automatic logic [1:0] decode(input logic [3:0] c);
        case (c)
            PAT_ONE: return SYM_ONE;
            PAT_ZERO: return SYM_ZERO;
            PAT_OPEN: return SYM_OPEN;
            default: return 2'h3;
        endcase
    endfunction : decode

    // Mid-chip sampling, one word per 80 chips
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            chips <= 4'h0;
            acc <= '0;
            wordValid <= 1'b0;
            wordSyms <= '0;
            addrMatch <= 1'b0;
            dataOut <= 8'h00;
        end else begin
            wordValid <= 1'b0;
            cnt <= txActive ? cnt + 1 : 0;
            if (txActive && cnt % CHIP == CHIP / 2) begin
                chips <= {chips[2:0], txData};
                if (chipIdx < 4 * WORD_BITS && chipIdx % 4 == 3) begin
                    acc[2*(chipIdx/4)+:2] <= decode({chips[2:0], txData});
                end
                if (chipIdx == 4 * WORD_BITS + GAP_CHIPS - 1) begin
                    wordValid <= 1'b1;
                    wordSyms <= acc;
                    addrMatch <= (acc[2*ADDR_W-1:0] == localSyms);
                    for (int i = 0; i < DATA_W; i++) begin
                        dataOut[i] <= (acc[2*(ADDR_W+i)+:2] == 2'h1);
                    end
                end
            end
        end
    end
endmodule : rce_rx_model
`default_nettype wire

// file: verification/rce_encoder_bench.sv
// Self-checking bench for the remote-control encoder
`default_nettype none
module rce_encoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rce_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sendTrigger = 1'b0;
    logic [9:0] addrLines = 10'h155;
    logic [9:0] drvA = 10'h3FF;
    logic [7:0] dataLines = 8'h00;
    logic [7:0] drvD = 8'hFF;
    logic [2:0] cfg = 3'h0;
    logic [2:0] drvC = 3'h7;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic txData;
    logic txActive;
    logic wordValid;
    logic [35:0] wordSyms;
    logic [19:0] localSyms = 20'h0;
    logic [35:0] expQ[$];
    logic [35:0] expW;
    logic [7:0] expData;
    logic [7:0] rxData;
    int error_cnt = 0;
    int n_tests = 0;

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    rce_encoder #(.CHIP_CYCLES(4), .LAG_CYCLES(2000)) i_rce_encoder (
        .ref_clk(ref_clk), .rst_n(rst_n), .sendTrigger(sendTrigger),
        .addressWordLines(addrLines), .addressWordLinesDriven(drvA),
        .payloadLines(dataLines), .payloadLinesDriven(drvD),
        .dataBitTypeSelect(cfg[0]), .dataBitTypeSelectDriven(drvC[0]),
        .addrBitTypeSelectLo(cfg[1]), .addrBitTypeSelectLoDriven(drvC[1]),
        .addrBitTypeSelectHi(cfg[2]), .addrBitTypeSelectHiDriven(drvC[2]),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txData(txData), .txActive(txActive)
    );

    rce_rx_model #(.CHIP(4)) i_rce_rx_model (
        .ref_clk(ref_clk), .rst_n(rst_n), .txData(txData), .txActive(txActive),
        .localSyms(localSyms), .wordValid(wordValid), .wordSyms(wordSyms),
        .addrMatch(), .dataOut(rxData)
    );

    task automatic check(input string what, input logic [35:0] expV, input logic [35:0] gotV);
        n_tests++;
        if (gotV !== expV) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, expV, gotV);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic timeout(input string what);
        error_cnt++;
        $display("ERROR %s expected response seen none", what);
        report_and_stop();
    endtask : timeout

    // Received words against the oldest expected word
    always @(posedge ref_clk) begin
        if (wordValid === 1'b1) begin
            if (expQ.size() == 0) begin
                error_cnt++;
                $display("ERROR wordSyms expected none seen %h", wordSyms);
            end else begin
                expW = expQ.pop_front();
                check("wordSyms", expW, wordSyms);
                for (int i = 0; i < 8; i++) begin
                    expData[i] = expW[20+2*i+:2] == 2'h1;
                end
                check("dataOut", {28'h0, expData}, {28'h0, rxData});
            end
        end
    end

    function automatic logic [1:0] sym(input logic lv, input logic hiOpen, input logic loOpen);
        if (lv) begin
            return hiOpen ? 2'h2 : 2'h1;
        end
        return loOpen ? 2'h2 : 2'h0;
    endfunction : sym

    function automatic logic [9:0] rand_addr();
        logic [9:0] a;
        a = 10'($urandom);
        if (a == 10'h000 || a == 10'h3FF) a = 10'h2A5;
        return a;
    endfunction : rand_addr

    task automatic push_exp(input logic [9:0] a, input logic [7:0] d, input logic [2:0] c);
        logic [35:0] w;
        for (int i = 0; i < 10; i++) begin
            w[2*i+:2] = sym(a[i], c[2] & !c[1], !c[2] & c[1]);
        end
        for (int i = 0; i < 8; i++) begin
            w[20+2*i+:2] = sym(d[i], 1'b0, !c[0]);
        end
        localSyms <= w[19:0];
        repeat (3) expQ.push_back(w);
    endtask : push_exp

    task automatic set_pins(input logic [9:0] a, input logic [7:0] d, input logic [2:0] c);
        addrLines <= a;
        dataLines <= d;
        cfg <= c;
    endtask : set_pins

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] expD, input logic expErr);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1) timeout("pready");
        if (!wr) check("prdata", {4'h0, expD}, {4'h0, prdata});
        check("pslverr", {35'h0, expErr}, {35'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb

    task automatic wait_tx(input logic lvl, input int lim);
        int k;
        k = 0;
        while (txActive !== lvl && k < lim) begin
            @(posedge ref_clk);
            k++;
        end
        if (txActive !== lvl) timeout("txActive");
    endtask : wait_tx

    task automatic start_tx(input logic sw);
        repeat (4) @(posedge ref_clk);
        if (sw) apb(1'b1, CTRL_OFS, 32'h3, 32'h0, 1'b0);
        else sendTrigger <= 1'b1;
        wait_tx(1'b1, 20);
    endtask : start_tx

    task automatic stop_tx(input logic sw);
        if (sw) apb(1'b1, CTRL_OFS, 32'h1, 32'h0, 1'b0);
        else sendTrigger <= 1'b0;
        wait_tx(1'b0, 4000);
        repeat (8) @(posedge ref_clk);
        check("pending words", 36'h0, 36'(expQ.size()));
    endtask : stop_tx

    initial begin
        logic [9:0] a;
        logic [7:0] d;
        void'($urandom(32'hF1F1FF84));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        apb(1'b0, CTRL_OFS, 32'h0, 32'h1, 1'b0);
        apb(1'b1, 8'h14, 32'h3, 32'h0, 1'b1);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        repeat (10) @(posedge ref_clk);
        check("txActive", 36'h0, {35'h0, txActive});
        $display("test register access done");
        for (int c = 0; c < 8; c++) begin
            a = rand_addr();
            d = 8'($urandom);
            set_pins(a, d, 3'(c));
            push_exp(a, d, 3'(c));
            start_tx(c[0]);
            apb(1'b0, CAPT_OFS, 32'h0, {11'h000, 3'(c), d, a}, 1'b0);
            repeat (100) @(posedge ref_clk);
            stop_tx(c[0]);
        end
        apb(1'b0, STAT_OFS, 32'h0, 32'h00080000, 1'b0);
        $display("test coding selects done");
        drvA <= 10'h0F0;
        drvD <= 8'h00;
        drvC <= 3'h0;
        set_pins(10'h000, 8'hFF, 3'h3);
        push_exp(10'h30F, 8'h00, 3'h4);
        start_tx(1'b0);
        apb(1'b0, PINS_OFS, 32'h0, 32'h000030F9, 1'b0);
        repeat (100) @(posedge ref_clk);
        stop_tx(1'b0);
        drvA <= 10'h3FF;
        drvD <= 8'hFF;
        drvC <= 3'h7;
        $display("test floating pins done");
        a = rand_addr();
        d = 8'($urandom);
        set_pins(a, d, 3'h6);
        push_exp(a, d, 3'h6);
        start_tx(1'b0);
        repeat (400) @(posedge ref_clk);
        a = rand_addr();
        d = 8'($urandom);
        set_pins(a, d, 3'h1);
        push_exp(a, d, 3'h1);
        repeat (960) @(posedge ref_clk);
        stop_tx(1'b0);
        $display("test continuous sending done");
        report_and_stop();
    end
endmodule : rce_encoder_bench
`default_nettype wire
